/* rtl/sgl_start_guard.sv */
// Purpose: Unattended start guard and parameter edit lock.
// Assumes: Contact inputs are asynchronous; registers on Avalon-MM.
// Notes:   Run output follows the guard state machine below.
`timescale 1ns/1ps
// Notes on behaviour
// - With the guard off, a run request present at power-up starts the output once power-up ends.
// - With the guard on and run requested at power-up, the output stays off and the guard fault shows.
// - A guard trip clears only on run release, fault-clear input or keypad stop/reset.
// - After clearing by run release, a new run request starts the output normally.
// - Clearing by fault-clear while run is still held resumes running at once.
// - Clearing an undervoltage trip by fault-clear pulse reapplies the guard check.
// - Function code 13 selects the guard input; it is checked only when power-up ends, so a fault-clear of a guard trip resumes a held run either way.
// - Function code 15 selects the edit lock input which refuses keypad and remote edits.
// - The frequency lock setting decides if the frequency setpoint stays editable under lock.
// - With the edit lock off, edits are accepted and stored.
// - The alarm output drops within 30 ms of the start of the clear command.
module sgl_start_guard
	import sgl_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	input  wire logic         clkEn,
	input  wire logic [4:0]   contactIn,
	input  wire logic         runRequest,
	input  wire logic         keyStopReset,
	input  wire logic         editReq,
	input  wire sgl_pkg::sgl_src_t editSrc,
	input  wire logic         editIsFreq,
	output logic              editAccept,
	output logic              editRefuse,
	output logic              runOut,
	output logic              alarmOut,
	output logic [7:0]        faultCode,
	input  wire logic [3:0]   avs_address,
	input  wire logic         avs_read,
	input  wire logic         avs_write,
	input  wire logic [31:0]  avs_writedata,
	input  wire logic [3:0]   avs_byteenable,
	output logic [31:0]       avs_readdata,
	output logic              avs_waitrequest
);
	import sgl_pkg::*;

	typedef enum logic [2:0] {
		ST_POWERUP, ST_STOP, ST_RUN, ST_GUARD_TRIP, ST_UV_TRIP
	} sgl_state_t;

	logic [5:0]  syncIn;
	logic [31:0] ctrl_r;
	logic [39:0] func_r;
	logic [31:0] editStore_r;
	logic        rdAck_r;
	logic        wrAck_r;
	sgl_state_t  state_r;
	sgl_state_t  state_nxt;
	logic [15:0] settle_r;
	logic        clrPrev_r;
	logic        clrFall;
	logic        clrRise;
	logic        runIn;
	logic        guardOn;
	logic        lockOn;
	logic        clrIn;
	logic        clrAny;
	logic        lockBlocks;
	logic        runPrev_r;
	logic        runRise;

	// Returns high if any input is assigned the function and is on
	function automatic logic fnActive(input logic [39:0] fs,
		input logic [4:0] pins, input logic [7:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			if (fs[i*8 +: 8] == code && pins[i])
				hit = 1'b1;
		end
		return hit;
	endfunction : fnActive

	// Merges a bus write into a word under byte enables
	function automatic logic [31:0] beMerge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b])
				res[b*8 +: 8] = wd[b*8 +: 8];
		end
		return res;
	endfunction : beMerge

	// Contacts and run request come from pins
	sgl_sync #(.W(6)) uSync (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.clkEn   (clkEn),
		.asyncIn ({runRequest, contactIn}),
		.syncOut (syncIn)
	);

	assign runIn   = syncIn[5];
	assign guardOn = fnActive(func_r, syncIn[4:0], FUNC_START_GUARD);
	assign lockOn  = fnActive(func_r, syncIn[4:0], FUNC_EDIT_LOCK);
	assign clrIn   = fnActive(func_r, syncIn[4:0], FUNC_FAULT_CLR);

	// Fault-clear edges: start on rise, act on fall
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			clrPrev_r <= 1'b0;
		else if (clkEn)
			clrPrev_r <= clrIn;
	end
	assign clrRise = clrIn & ~clrPrev_r;
	assign clrFall = ~clrIn & clrPrev_r;
	assign clrAny  = clrFall | keyStopReset;

	// Run request edge: a stopped drive starts only on a fresh request,
	// so a keypad clear with run still held does not restart the motor
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			runPrev_r <= 1'b0;
		else if (clkEn)
			runPrev_r <= runIn;
	end
	assign runRise = runIn & ~runPrev_r;

	// Power-up settle counter
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			settle_r <= '0;
		else if (clkEn && state_r == ST_POWERUP)
			settle_r <= settle_r + 16'h0001;
		else if (clkEn)
			settle_r <= '0;
	end

	// Drive state machine
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_POWERUP: begin
				if (settle_r >= 16'(SETTLE_CYC - 1)) begin
					if (runIn && guardOn)
						state_nxt = ST_GUARD_TRIP;
					else if (runIn)
						state_nxt = ST_RUN;
					else
						state_nxt = ST_STOP;
				end
			end
			ST_STOP: begin
				if (runRise)
					state_nxt = ST_RUN;
			end
			ST_RUN: begin
				if (ctrl_r[CTRL_UV_TRIP])
					state_nxt = ST_UV_TRIP;
				else if (!runIn)
					state_nxt = ST_STOP;
			end
			ST_GUARD_TRIP: begin
				if (clrFall && runIn)
					state_nxt = ST_RUN;
				else if (clrAny || !runIn)
					state_nxt = ST_STOP;
			end
			ST_UV_TRIP: begin
				if (clrFall)
					state_nxt = ST_POWERUP;
			end
			default: state_nxt = ST_POWERUP;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			state_r <= ST_POWERUP;
		else if (clkEn)
			state_r <= state_nxt;
	end

	// Outputs from the state; alarm drops on the clear rising edge
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			runOut    <= 1'b0;
			alarmOut  <= 1'b0;
			faultCode <= FAULT_NONE;
		end else if (clkEn) begin
			runOut   <= (state_nxt == ST_RUN);
			alarmOut <= (state_nxt == ST_GUARD_TRIP ||
				state_nxt == ST_UV_TRIP) && !clrRise && !clrIn;
			case (state_nxt)
				ST_GUARD_TRIP: faultCode <= START_GUARD_FAULT_CODE;
				ST_UV_TRIP:    faultCode <= UNDERVOLTAGE_FAULT_CODE;
				default:       faultCode <= FAULT_NONE;
			endcase
		end
	end

	// Edit lock decision, keypad or remote alike
	assign lockBlocks = lockOn &&
		!(editIsFreq && !ctrl_r[CTRL_FREQ_LOCK]);
	assign editAccept = editReq && !lockBlocks;
	assign editRefuse = editReq && lockBlocks;

	// Bus slave: one wait cycle then acknowledge
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rdAck_r <= 1'b0;
			wrAck_r <= 1'b0;
		end else if (clkEn) begin
			rdAck_r <= avs_read && !rdAck_r;
			wrAck_r <= avs_write && !wrAck_r;
		end
	end
	assign avs_waitrequest = (avs_read && !rdAck_r) ||
		(avs_write && !wrAck_r);

	// Register writes; edit store refuses writes under lock
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ctrl_r      <= CTRL_RESET;
			func_r      <= {FUNC_NONE, FUNC_NONE, FUNC_NONE, FUNC_NONE,
				FUNC_NONE};
			editStore_r <= '0;
		end else if (clkEn && avs_write && wrAck_r) begin
			case (avs_address)
				OFF_CTRL: ctrl_r <= beMerge(ctrl_r, avs_writedata,
					avs_byteenable);
				OFF_FUNC: func_r[31:0] <= beMerge(func_r[31:0],
					avs_writedata, avs_byteenable);
				OFF_EDIT: begin
					if (!lockOn)
						editStore_r <= beMerge(editStore_r,
							avs_writedata, avs_byteenable);
				end
				default: ;
			endcase
		end else if (clkEn && editAccept) begin
			editStore_r <= editStore_r + 32'h0000_0001;
		end
	end

	// Read data, reads allowed under lock
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			avs_readdata <= '0;
		else if (clkEn && avs_read && !rdAck_r) begin
			case (avs_address)
				OFF_CTRL:   avs_readdata <= ctrl_r;
				OFF_STATUS: avs_readdata <= {16'h0000, faultCode,
					3'b000, lockOn, guardOn, alarmOut, runOut,
					runIn};
				OFF_FUNC:   avs_readdata <= func_r[31:0];
				OFF_EDIT:   avs_readdata <= editStore_r;
				default:    avs_readdata <= '0;
			endcase
		end
	end
endmodule : sgl_start_guard

/* include/sgl_pkg.sv */
// Purpose: Shared constants for the start guard and edit lock block.
// Assumes: 250 MHz ref_clk, Avalon-MM register slave with 32-bit data.
// Notes:   Offsets are byte addresses of aligned words.
package sgl_pkg;
	localparam int          CLK_MHZ         = 250;
	// Register byte offsets
	localparam logic [3:0]  OFF_CTRL        = 4'h0;
	localparam logic [3:0]  OFF_STATUS      = 4'h4;
	localparam logic [3:0]  OFF_FUNC        = 4'h8;
	localparam logic [3:0]  OFF_EDIT        = 4'hC;
	// Control register fields
	localparam int          CTRL_FREQ_LOCK  = 0;
	localparam int          CTRL_UV_TRIP    = 1;
	localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
	// Input function codes, one 8-bit field per input
	localparam int          NUM_INPUTS      = 5;
	localparam logic [7:0]  FUNC_START_GUARD = 8'h0D;
	localparam logic [7:0]  FUNC_EDIT_LOCK  = 8'h0F;
	localparam logic [7:0]  FUNC_FAULT_CLR  = 8'h12;
	localparam logic [7:0]  FUNC_NONE       = 8'hFF;
	// Fault codes shown on the display
	localparam logic [7:0]  FAULT_NONE      = 8'h00;
	localparam logic [7:0]  START_GUARD_FAULT_CODE   = 8'h0D;
	localparam logic [7:0]  UNDERVOLTAGE_FAULT_CODE  = 8'h09;
	// Timing: alarm must drop within 30 ms of the clear command
	localparam int          ALARM_CLR_MS    = 30;
	localparam int          ALARM_CLR_CYC   = ALARM_CLR_MS * 1000 * CLK_MHZ;
	// Settle time after power-up before the run request is judged
	localparam int          SETTLE_US       = 1;
	localparam int          SETTLE_CYC      = SETTLE_US * CLK_MHZ;
	// Edit request source
	typedef enum logic {SRC_KEYPAD, SRC_REMOTE} sgl_src_t;
endpackage : sgl_pkg

/* rtl/sgl_sync.sv */
// Purpose: Two-flop synchroniser for the contact inputs.
// Assumes: Inputs are asynchronous levels from external contacts.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
module sgl_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	input  wire logic         clkEn,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);
	logic [W-1:0] meta_r;

	// Two stage capture
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			meta_r  <= '0;
			syncOut <= '0;
		end else if (clkEn) begin
			meta_r  <= asyncIn;
			syncOut <= meta_r;
		end
	end
endmodule : sgl_sync

/* bench/sgl_monitor.sv */
// Purpose: Port checker for the start guard and edit lock block.
// Assumes: Bench maps guard to input 0, lock to 1, fault-clear to 2.
// Notes:   Bound to the top module after endmodule.
`timescale 1ns/1ps
module sgl_monitor
	import sgl_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       sys_rst,
	input wire logic [4:0] contactIn,
	input wire logic       runRequest,
	input wire logic       keyStopReset,
	input wire logic       editReq,
	input wire logic       editAccept,
	input wire logic       editRefuse,
	input wire logic       runOut,
	input wire logic       alarmOut,
	input wire logic [7:0] faultCode,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// Edit answers and trip relations
	property p_excl; editReq |-> editAccept != editRefuse; endproperty
	a_excl: assert property (p_excl) else $error("edit answer bad");
	property p_idle; !editReq |-> !editAccept && !editRefuse; endproperty
	a_idle: assert property (p_idle) else $error("edit idle bad");
	// Alarm may drop early while fault-clear is held or just released
	property p_gcode;
		faultCode == START_GUARD_FAULT_CODE |-> !runOut &&
			(alarmOut || contactIn[2] || $past(contactIn[2], 3));
	endproperty
	a_gcode: assert property (p_gcode) else $error("guard trip bad");
	property p_uv; faultCode == UNDERVOLTAGE_FAULT_CODE |-> !runOut; endproperty
	a_uv: assert property (p_uv) else $error("uv trip runs");
	property p_clr; $rose(contactIn[2]) && alarmOut |-> ##[1:8] !alarmOut;
	endproperty
	a_clr: assert property (p_clr) else $error("alarm not cleared");
	property p_key; keyStopReset && faultCode == START_GUARD_FAULT_CODE
		|-> ##[1:4] (!alarmOut && !runOut); endproperty
	a_key: assert property (p_key) else $error("key clear bad");
	property p_rel; faultCode == START_GUARD_FAULT_CODE && $fell(runRequest)
		|-> ##[1:6] faultCode == FAULT_NONE; endproperty
	a_rel: assert property (p_rel) else $error("release clear bad");
	property p_wt; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wt: assert property (p_wt) else $error("bus stall");
	// Main scenarios
	c_trip: cover property (faultCode == START_GUARD_FAULT_CODE);
	c_ref: cover property (editRefuse);
	c_run: cover property ($rose(runOut));
endmodule : sgl_monitor
bind sgl_start_guard sgl_monitor i_mon (.ref_clk, .sys_rst, .contactIn,
	.runRequest, .keyStopReset, .editReq, .editAccept, .editRefuse, .runOut,
	.alarmOut, .faultCode, .avs_read, .avs_write, .avs_waitrequest);

/* bench/sgl_contacts.sv */
// Purpose: Operator contact model driving the run and function inputs.
// Assumes: Clear hold is shortened, the block acts on the release edge.
// Notes:   Spare contacts are open and read low through pull-downs.
`timescale 1ns/1ps
module sgl_contacts #(
	parameter int CLR_HOLD = 20
) (
	input  wire logic       ref_clk,
	input  wire logic       runCmd,
	input  wire logic       guardOn,
	input  wire logic       lockOn,
	input  wire logic       clrGo,
	output logic [4:0]      contactIn,
	output logic            runRequest
);
	int cnt = 0;
	// Hold fault-clear on for a full pulse before release
	always @(posedge ref_clk) if (clrGo) cnt <= CLR_HOLD;
		else if (cnt != 0) cnt <= cnt - 1;
	assign contactIn = {2'b00, cnt != 0, lockOn, guardOn};
	assign runRequest = runCmd;
endmodule : sgl_contacts

/* bench/tb.sv */
// Purpose: Self-checking bench for the start guard and edit lock block.
// Assumes: Inputs 0..2 carry guard, lock and fault-clear functions.
// Notes:   Expected levels come from a small model kept in the bench.
`timescale 1ns/1ps
module tb;
	import sgl_pkg::*;
	logic ref_clk = 0, sys_rst = 1, runCmd = 0, guardOn = 0, lockOn = 0;
	logic clrGo = 0, keyStopReset = 0, editReq = 0, editIsFreq = 0;
	logic avs_read = 0, avs_write = 0, expA;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, rd, v, rnd = 32'h5697;
	logic [4:0] contactIn;
	logic runRequest, editAccept, editRefuse, runOut, alarmOut;
	logic [7:0] faultCode;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	sgl_src_t editSrc = SRC_KEYPAD;
	int n_mismatch = 0, n_compared = 0, cyc = 0, mRun, mAl, mF;
	sgl_contacts i_con (.ref_clk, .runCmd, .guardOn, .lockOn, .clrGo,
		.contactIn, .runRequest);
	sgl_start_guard i_dut (.ref_clk, .sys_rst, .clkEn(1'b1), .contactIn,
		.runRequest, .keyStopReset, .editReq, .editSrc, .editIsFreq,
		.editAccept, .editRefuse, .runOut, .alarmOut, .faultCode,
		.avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest);
	initial forever #2 ref_clk = ~ref_clk;
	// Cycle ceiling against hangs
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic st(input string t);
		chk("runOut", mRun, runOut);
		chk("alarmOut", mAl, alarmOut);
		chk("faultCode", mF, faultCode);
		$display("test %s done", t);
	endtask : st
	// One Avalon-MM transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic boot(input logic g, input logic r);
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		guardOn <= g;
		runCmd <= r;
		bus(1, OFF_FUNC, {8'hFF, FUNC_FAULT_CLR, FUNC_EDIT_LOCK,
			FUNC_START_GUARD});
		repeat (300) @(posedge ref_clk);
		mRun = r && !g;
		mAl = r && g;
		mF = (r && g) ? START_GUARD_FAULT_CODE : FAULT_NONE;
	endtask : boot
	task automatic clr();
		clrGo <= 1'b1;
		@(posedge ref_clk);
		clrGo <= 1'b0;
		repeat (300) @(posedge ref_clk);
	endtask : clr
	task automatic lev(input logic r, input int n);
		runCmd <= r;
		repeat (n) @(posedge ref_clk);
	endtask : lev
	task give_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : give_verdict
	initial begin
		boot(0, 1); st("unguarded");
		boot(1, 1); st("guarded");
		lev(0, 20); mAl = 0; mF = 0; st("release");
		lev(1, 20); mRun = 1; st("restart");
		boot(1, 1); clr(); mRun = 1; mAl = 0; mF = 0; st("clear");
		boot(1, 1);
		keyStopReset <= 1'b1;
		@(posedge ref_clk);
		keyStopReset <= 1'b0;
		repeat (20) @(posedge ref_clk);
		mAl = 0; mF = 0; st("key");
		lev(0, 20); lev(1, 20); bus(1, OFF_CTRL, 32'h2); repeat (10) @(posedge ref_clk);
		mRun = 0; mAl = 1; mF = UNDERVOLTAGE_FAULT_CODE; st("uv");
		bus(1, OFF_CTRL, 32'h0); clr(); mF = START_GUARD_FAULT_CODE; st("uvclr");
		// Every lock, frequency-lock and target combination
		for (int i = 0; i < 8; i++) begin
			bus(1, OFF_CTRL, {31'h0, i[1]});
			lockOn <= i[2];
			repeat (10) @(posedge ref_clk);
			rnd = xs(rnd);
			editReq <= 1'b1;
			editIsFreq <= i[0];
			editSrc <= sgl_src_t'(rnd[0]);
			@(posedge ref_clk);
			// Answers are combinational and settled before this edge
			expA = !i[2] || (i[0] && !i[1]);
			chk("editAccept", expA, editAccept);
			chk("editRefuse", !expA, editRefuse);
			editReq <= 1'b0;
		end
		$display("test edit done");
		bus(0, OFF_EDIT, 0); v = rd; rnd = xs(rnd); bus(1, OFF_EDIT, rnd);
		bus(0, OFF_EDIT, 0); chk("storeLocked", v, rd);
		lockOn <= 1'b0; repeat (10) @(posedge ref_clk); rnd = xs(rnd);
		bus(1, OFF_EDIT, rnd); bus(0, OFF_EDIT, 0); chk("store", rnd, rd);
		bus(0, 4'h1, 0); chk("unmapped", 32'h0, rd);
		$display("test store done");
		give_verdict();
	end
endmodule : tb
